// ==== rtl/rps_pkg.sv ====
// constants, types and register map of the rom port and reset strap block
package rps_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] RPS_OFF_CTRL   = 5'h00;
    localparam logic [4:0] RPS_OFF_STATUS = 5'h04;
    localparam logic [4:0] RPS_OFF_ADDR   = 5'h08;
    localparam logic [4:0] RPS_OFF_DATA   = 5'h0c;
    // control register bits (write 1 to act)
    localparam int RPS_CTRL_CLR_LOCK = 0;
    localparam int RPS_CTRL_PRELOAD  = 1;
    // status register bit positions
    localparam int RPS_ST_STRAP_LSB  = 0;
    localparam int RPS_ST_LOCKOUT    = 8;
    localparam int RPS_ST_BUSY       = 9;
    localparam int RPS_ST_PRE_OK     = 10;
    localparam int RPS_ST_PRE_ABORT  = 11;
    // strap positions on the shared rom bus
    localparam int RPS_PIN_ARB       = 7;
    localparam int RPS_PIN_CENTRAL   = 6;
    localparam int RPS_PIN_SCLK      = 5;
    localparam int RPS_PIN_ASYNC     = 4;
    localparam int RPS_PIN_LOCK      = 3;
    // serial rom lines on the shared rom bus
    localparam int RPS_PIN_SERIAL_ROM_DATA_FROM_ROM     = 2;
    localparam int RPS_PIN_SERIAL_ROM_DATA_TO_ROM     = 1;
    localparam int RPS_PIN_SERIAL_ROM_CLOCK_OUT     = 0;
    // clocks after reset release before the synchronised pins are valid
    localparam logic [1:0] RPS_CAP_WAIT    = 2'h2;
    // latch clock periods the data byte stands on the bus
    localparam logic [1:0] RPS_DATA_TICKS  = 2'h2;
    // serial preload enable pattern, first bit then second
    localparam logic [1:0] RPS_PRE_PATTERN = 2'h2;
    localparam logic [23:0] RPS_ADDR_RST   = 24'h000000;
    localparam logic [7:0]  RPS_DATA_RST   = 8'h00;

    // configuration taken from the bus just after primary reset is released
    typedef struct packed {
        logic arb_pin;     // low: internal arbiter off
        logic central_pin; // low: central function drives
        logic sclk_pin;    // low: secondary clock held low
        logic async_pin;   // high: asynchronous interfaces
        logic lock_pin;    // reset value of primary lockout
    } rps_strap_t;
    localparam rps_strap_t RPS_STRAP_RST = 5'h1f;

    typedef enum logic [2:0] {
        RPS_IDLE    = 3'b000,
        RPS_ADDR2   = 3'b001,
        RPS_ADDR1   = 3'b010,
        RPS_ADDR0   = 3'b011,
        RPS_DATA    = 3'b100,
        RPS_SR_LOW  = 3'b101,
        RPS_SR_HIGH = 3'b110,
        RPS_DONE    = 3'b111
    } rps_state_t;
endpackage

// ==== rtl/rps_rom_port.sv ====
// rom port sequencer, serial preload check and reset strap capture
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
// Summary of operation
// - parallel rom gets address bytes 23:16, 15:8, 7:0, then data byte.
// - serial rom uses bus bit 2 in, bit 1 out, bit 0 clock.
// - bus bits 7 to 3 are configuration straps captured as primary reset ends.
// - strap bit 7 low disables internal arbiter.
// - strap bit 6 low drives req64 and secondary bus low during secondary reset.
// - strap bit 5 low holds secondary clock low, else primary clock copy.
// - strap bit 4 high selects asynchronous interfaces, low synchronous.
// - strap bit 3 sets lockout reset value; software clears lockout.
// - preload proceeds only on pattern 10b, else stops at the first bit that differs.
// - bit 2 is sampled during first serial read, not at reset.
// - latch enable low from first address byte until last address byte.
// - latch clock output is system clock divided by two.
// - primary reset is asynchronous and sets all register state to its reset value.
module rps_rom_port (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [7:0]  rom_ad_bus_i,
    output logic [7:0]       rom_ad_bus_o,
    output logic [7:0]       rom_ad_bus_oe,
    output logic             rom_address_latch_enable_n,
    output logic             rom_latch_clock,
    output logic             serial_rom_select,
    input  wire logic        sec_reset_active,
    output logic             secondary_req64_pin_o,
    output logic             secondary_req64_pin_oe,
    output logic             sec_bus_zero_oe,
    output logic             internal_arbiter_en,
    output logic             sec_clk_out_en,
    output logic             async_mode,
    output logic             primary_lockout
);
    import rps_pkg::*;

    logic [7:0]  pin_meta_reg, pin_sync_reg;
    logic        div_reg, div_next, tick;
    logic [1:0]  cap_cnt_reg, cap_cnt_next;
    logic        captured_reg, captured_next, lock_reg, lock_next;
    rps_strap_t  strap_reg, strap_next;
    logic        pre_req_reg, pre_req_next, pre_ok_reg, pre_ok_next;
    logic        pre_abort_reg, pre_abort_next, serial_reg, serial_next;
    rps_state_t  state_reg, state_next;
    logic        wr_dir_reg, wr_dir_next, bit_cnt_reg, bit_cnt_next;
    logic [1:0]  phase_reg, phase_next;
    logic [23:0] addr_reg, addr_next;
    logic [7:0]  wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic        ack_reg, ack_next, ale_n_reg, ale_n_next, sr_sel_reg, sr_sel_next;
    logic [31:0] readdata_reg, readdata_next;
    logic [7:0]  bus_o_reg, bus_o_next;
    logic [7:0]  bus_oe_reg, bus_oe_next;
    logic        req, rom_acc, serial_rom_data_from_rom, wr_take, pre_set;

    // bus pins come from the board, so two flops before any use
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end else begin
            pin_meta_reg <= rom_ad_bus_i;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign serial_rom_data_from_rom = pin_sync_reg[RPS_PIN_SERIAL_ROM_DATA_FROM_ROM];
    assign req     = avs_read | avs_write;
    assign rom_acc = req && (avs_address == RPS_OFF_DATA);
    assign tick    = div_reg;
    assign wr_take = avs_write && ack_reg && !rom_acc; // write lands as waitrequest is low
    assign pre_set = wr_take && (avs_address == RPS_OFF_CTRL) && avs_writedata[RPS_CTRL_PRELOAD];

    // next state of straps, registers, bus slave and the rom sequencer
    always_comb begin
        div_next       = ~div_reg;
        cap_cnt_next   = cap_cnt_reg;
        captured_next  = captured_reg;
        strap_next     = strap_reg;
        lock_next      = lock_reg;
        pre_req_next   = pre_req_reg;
        pre_ok_next    = pre_ok_reg;
        pre_abort_next = pre_abort_reg;
        state_next     = state_reg;
        serial_next    = serial_reg;
        wr_dir_next    = wr_dir_reg;
        bit_cnt_next   = bit_cnt_reg;
        phase_next     = phase_reg;
        addr_next      = addr_reg;
        wdata_next     = wdata_reg;
        rdata_next     = rdata_reg;
        ack_next       = 1'b0;
        readdata_next  = readdata_reg;
        bus_o_next     = bus_o_reg;
        bus_oe_next    = bus_oe_reg;
        ale_n_next     = ale_n_reg;
        sr_sel_next    = sr_sel_reg;

        // bus is not driven until straps are in, so the resistors still set it
        if (!captured_reg) begin
            if (cap_cnt_reg == RPS_CAP_WAIT) begin
                strap_next    = pin_sync_reg[7:3];
                lock_next     = pin_sync_reg[RPS_PIN_LOCK];
                captured_next = 1'b1;
                pre_req_next  = 1'b1;
            end else begin
                cap_cnt_next = cap_cnt_reg + 2'h1;
            end
        end

        // plain register accesses answer after one wait cycle
        if (req && !ack_reg && !rom_acc) begin
            ack_next      = 1'b1;
            readdata_next = 32'h00000000;
            if (avs_address == RPS_OFF_STATUS) begin
                readdata_next[RPS_ST_STRAP_LSB +: 5] = strap_reg;
                readdata_next[RPS_ST_LOCKOUT]        = lock_reg;
                readdata_next[RPS_ST_BUSY]           = state_reg != RPS_IDLE;
                readdata_next[RPS_ST_PRE_OK]         = pre_ok_reg;
                readdata_next[RPS_ST_PRE_ABORT]      = pre_abort_reg;
            end else if (avs_address == RPS_OFF_ADDR) begin
                readdata_next = {8'h00, addr_reg};
            end
        end
        // writes land only in the cycle that waitrequest is low; a clear before capture is lost
        if (wr_take && avs_address == RPS_OFF_ADDR) begin
            addr_next = avs_writedata[23:0];
        end else if (wr_take && avs_address == RPS_OFF_CTRL) begin
            if (avs_writedata[RPS_CTRL_CLR_LOCK] && captured_reg) begin
                lock_next = 1'b0;
            end
        end
        if (pre_set) begin
            pre_req_next = 1'b1;
        end

        // sequencer steps on the latch clock so bytes meet its rising edge
        if (tick) begin
            case (state_reg)
                RPS_IDLE: begin
                    bus_oe_next = 8'h00;
                    if (captured_reg && pre_req_reg) begin
                        pre_req_next   = pre_set; // a request landing now is kept
                        pre_ok_next    = 1'b0;
                        pre_abort_next = 1'b0;
                        serial_next    = 1'b1;
                        bit_cnt_next   = 1'b0;
                        sr_sel_next    = 1'b1;
                        bus_o_next     = 8'h00;
                        bus_oe_next    = 8'h03;
                        state_next     = RPS_SR_LOW;
                    end else if (captured_reg && rom_acc && !ack_reg) begin
                        serial_next = 1'b0;
                        wr_dir_next = avs_write;
                        wdata_next  = avs_writedata[7:0];
                        bus_o_next  = addr_reg[23:16];
                        bus_oe_next = 8'hff;
                        ale_n_next  = 1'b0;
                        state_next  = RPS_ADDR2;
                    end
                end
                RPS_ADDR2: begin
                    bus_o_next = addr_reg[15:8];
                    state_next = RPS_ADDR1;
                end
                RPS_ADDR1: begin
                    bus_o_next = addr_reg[7:0];
                    state_next = RPS_ADDR0;
                end
                RPS_ADDR0: begin
                    ale_n_next  = 1'b1;
                    bus_o_next  = wr_dir_reg ? wdata_reg : 8'h00;
                    bus_oe_next = wr_dir_reg ? 8'hff : 8'h00;
                    phase_next  = 2'h0;
                    state_next  = RPS_DATA;
                end
                RPS_DATA: begin
                    if (phase_reg == RPS_DATA_TICKS - 2'h1) begin
                        rdata_next  = pin_sync_reg;
                        bus_oe_next = 8'h00;
                        state_next  = RPS_DONE;
                    end else begin
                        phase_next = phase_reg + 2'h1;
                    end
                end
                RPS_SR_LOW: begin
                    bus_o_next[RPS_PIN_SERIAL_ROM_CLOCK_OUT] = 1'b1;
                    state_next = RPS_SR_HIGH;
                end
                RPS_SR_HIGH: begin
                    bus_o_next[RPS_PIN_SERIAL_ROM_CLOCK_OUT] = 1'b0;
                    // bit 2 is looked at here only, never at reset
                    if (serial_rom_data_from_rom != RPS_PRE_PATTERN[~bit_cnt_reg]) begin
                        pre_abort_next = 1'b1;
                        state_next     = RPS_DONE;
                    end else if (bit_cnt_reg) begin
                        pre_ok_next = 1'b1;
                        state_next  = RPS_DONE;
                    end else begin
                        bit_cnt_next = 1'b1;
                        state_next   = RPS_SR_LOW;
                    end
                end
                RPS_DONE: begin
                    bus_oe_next = 8'h00;
                    sr_sel_next = 1'b0;
                    state_next  = RPS_IDLE;
                    if (!serial_reg) begin
                        ack_next      = 1'b1;
                        readdata_next = {24'h000000, wr_dir_reg ? wdata_reg : rdata_reg};
                    end
                end
                default: state_next = RPS_IDLE;
            endcase
        end
    end

    // all state takes its reset value on primary reset regardless of the clock
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_reg       <= 1'b0;
            cap_cnt_reg   <= 2'h0;
            captured_reg  <= 1'b0;
            strap_reg     <= RPS_STRAP_RST;
            lock_reg      <= 1'b0;
            pre_req_reg   <= 1'b0;
            pre_ok_reg    <= 1'b0;
            pre_abort_reg <= 1'b0;
            state_reg     <= RPS_IDLE;
            serial_reg    <= 1'b0;
            wr_dir_reg    <= 1'b0;
            bit_cnt_reg   <= 1'b0;
            phase_reg     <= 2'h0;
            addr_reg      <= RPS_ADDR_RST;
            wdata_reg     <= RPS_DATA_RST;
            rdata_reg     <= RPS_DATA_RST;
            ack_reg       <= 1'b0;
            readdata_reg  <= 32'h00000000;
            bus_o_reg     <= 8'h00;
            bus_oe_reg    <= 8'h00;
            ale_n_reg     <= 1'b1;
            sr_sel_reg    <= 1'b0;
        end else begin
            div_reg       <= div_next;
            cap_cnt_reg   <= cap_cnt_next;
            captured_reg  <= captured_next;
            strap_reg     <= strap_next;
            lock_reg      <= lock_next;
            pre_req_reg   <= pre_req_next;
            pre_ok_reg    <= pre_ok_next;
            pre_abort_reg <= pre_abort_next;
            state_reg     <= state_next;
            serial_reg    <= serial_next;
            wr_dir_reg    <= wr_dir_next;
            bit_cnt_reg   <= bit_cnt_next;
            phase_reg     <= phase_next;
            addr_reg      <= addr_next;
            wdata_reg     <= wdata_next;
            rdata_reg     <= rdata_next;
            ack_reg       <= ack_next;
            readdata_reg  <= readdata_next;
            bus_o_reg     <= bus_o_next;
            bus_oe_reg    <= bus_oe_next;
            ale_n_reg     <= ale_n_next;
            sr_sel_reg    <= sr_sel_next;
        end
    end

    // pins and configuration levels; before capture the straps read as pulled high
    assign avs_waitrequest            = req && !ack_reg;
    assign avs_readdata               = readdata_reg;
    assign rom_ad_bus_o               = bus_o_reg;
    assign rom_ad_bus_oe              = bus_oe_reg;
    assign rom_address_latch_enable_n = ale_n_reg;
    assign rom_latch_clock            = div_reg;
    assign serial_rom_select          = sr_sel_reg;
    assign internal_arbiter_en        = strap_reg.arb_pin;
    assign sec_clk_out_en             = strap_reg.sclk_pin;
    assign async_mode                 = strap_reg.async_pin;
    assign primary_lockout            = lock_reg;
    // central resource parks req64 asserted and the bus at zero in secondary reset
    assign secondary_req64_pin_o      = 1'b0;
    assign secondary_req64_pin_oe     = sec_reset_active && !strap_reg.central_pin;
    assign sec_bus_zero_oe            = sec_reset_active && !strap_reg.central_pin;

    // checks on the sequencer and the strap holding
    chk_latch_enable_low: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_reg == RPS_ADDR2 || state_reg == RPS_ADDR1) |-> !rom_address_latch_enable_n)
        else $error("latch enable high during address bytes");
    chk_latch_clock_div: assert property (@(posedge clk_sys) disable iff (!nrst)
        rom_latch_clock |=> !rom_latch_clock ##1 rom_latch_clock)
        else $error("latch clock not half the system clock");
    chk_addr_byte_order: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_reg == RPS_ADDR2 && tick) |=> (rom_ad_bus_o == addr_reg[15:8])
        ##2 (rom_ad_bus_o == addr_reg[7:0]))
        else $error("address bytes out of order");
    chk_strap_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        captured_reg |=> $stable(strap_reg))
        else $error("strap changed after capture");
    chk_strap_taken: assert property (@(posedge clk_sys) disable iff (!nrst)
        (!captured_reg && cap_cnt_reg == RPS_CAP_WAIT)
        |=> (strap_reg == $past(pin_sync_reg[7:3])))
        else $error("strap not taken from the bus");
    chk_no_drive_reset: assert property (@(posedge clk_sys) disable iff (!nrst)
        !captured_reg |-> (rom_ad_bus_oe == 8'h00))
        else $error("bus driven before straps captured");
    chk_central_park: assert property (@(posedge clk_sys) disable iff (!nrst)
        (sec_reset_active && !strap_reg.central_pin) |-> secondary_req64_pin_oe
        && !secondary_req64_pin_o && sec_bus_zero_oe)
        else $error("central function not parked");
    chk_preload_abort: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_reg == RPS_SR_HIGH && tick && !bit_cnt_reg && !serial_rom_data_from_rom)
        |=> pre_abort_reg && state_reg == RPS_DONE)
        else $error("preload not stopped after first bit");
    chk_lockout_init: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(captured_reg) |-> (primary_lockout == strap_reg.lock_pin))
        else $error("lockout not set from strap");
    chk_serial_lines: assert property (@(posedge clk_sys) disable iff (!nrst)
        serial_rom_select |-> (rom_ad_bus_oe[7:2] == 6'h00))
        else $error("serial mode drives parallel lines");
    cov_preload_ok: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(pre_ok_reg));
    cov_preload_abort: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(pre_abort_reg));
    cov_rom_write: cover property (@(posedge clk_sys) disable iff (!nrst)
        state_reg == RPS_DATA && wr_dir_reg);
    cov_rom_read: cover property (@(posedge clk_sys) disable iff (!nrst)
        state_reg == RPS_DONE && !serial_reg && !wr_dir_reg);
endmodule

// ==== testbench/rps_rom_model.sv ====
// rom side model: strap resistors, serial enable pattern and parallel rom byte
`timescale 1ns/100ps
module rps_rom_model (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [7:0]  bus_o,
    input  wire logic [7:0]  bus_oe,
    input  wire logic        ale_n,
    input  wire logic        select,
    input  wire logic [4:0]  straps,
    input  wire logic [1:0]  pattern,
    input  wire logic [7:0]  rd_byte,
    output logic      [7:0]  bus_i,
    output logic      [23:0] addr_seen,
    output logic      [1:0]  addr_cnt
);
    logic [7:0] rom_drv;
    logic [7:0] last_lvl = 8'h00;
    logic       bit_idx  = 1'b0;
    logic       ck_d     = 1'b0;
    logic       ale_d    = 1'b1;
    // serial bit index steps on the falling serial clock, so a bit stands over the high phase
    always @(posedge clk_sys) begin
        ck_d <= bus_o[0];
        last_lvl <= bus_i;
        if (!select)
            bit_idx <= 1'b0;
        else if (ck_d && !bus_o[0] && bus_oe[0])
            bit_idx <= 1'b1;
    end
    // external latches: first byte on the falling latch enable, then each new byte
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            addr_cnt <= 2'h0;
            ale_d <= 1'b1;
        end else begin
            ale_d <= ale_n;
            if (ale_d && !ale_n && bus_oe == 8'hff) begin
                addr_seen <= {16'h0000, bus_o};
                addr_cnt <= 2'h1;
            end else if (!ale_n && bus_oe == 8'hff && addr_cnt != 2'h3
                         && bus_o != addr_seen[7:0]) begin
                addr_seen <= {addr_seen[15:0], bus_o};
                addr_cnt <= addr_cnt + 2'h1;
            end
        end
    end
    // wire level: design drive wins, then rom drive, then resistors; loose lines flip
    always_comb begin
        rom_drv = {straps, 1'b1, ~last_lvl[1:0]};
        if (select)
            rom_drv[2] = bit_idx ? pattern[0] : pattern[1];
        else if (nrst && ale_n && addr_cnt == 2'h3)
            rom_drv = rd_byte;
        for (int i = 0; i < 8; i++)
            bus_i[i] = bus_oe[i] ? bus_o[i] : rom_drv[i];
    end
endmodule

// ==== testbench/rom_port_reset_straps_tb.sv ====
// self-checking bench for the rom port sequencer and strap capture
`timescale 1ns/100ps
module rom_port_reset_straps_tb;
    import rps_pkg::*;
    typedef struct packed {logic [31:0] data; logic [31:0] mask;} rps_exp_t;
    logic        clk_sys = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, sec_rst = 1'b0;
    logic [4:0]  avs_address = 5'h00, straps = 5'h1f;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
    logic [7:0]  bus_i, bus_o, bus_oe, rd_byte = 8'h00;
    logic [1:0]  pattern = 2'h2, addr_cnt;
    logic [23:0] addr_seen, addr;
    logic        wreq, ale_n, lclk, lclk_d, sel, req_o, req_oe, zero_oe, arb, sclk, asy, lock;
    integer      seed = 20227, bad_count = 0, n_checks = 0, run_cnt = 0;
    rps_exp_t    exp_q[$];

    rps_rom_port uut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(wreq), .rom_ad_bus_i(bus_i),
        .rom_ad_bus_o(bus_o), .rom_ad_bus_oe(bus_oe), .rom_address_latch_enable_n(ale_n),
        .rom_latch_clock(lclk), .serial_rom_select(sel), .sec_reset_active(sec_rst),
        .secondary_req64_pin_o(req_o), .secondary_req64_pin_oe(req_oe),
        .sec_bus_zero_oe(zero_oe), .internal_arbiter_en(arb), .sec_clk_out_en(sclk),
        .async_mode(asy), .primary_lockout(lock));
    rps_rom_model rom (.clk_sys(clk_sys), .nrst(nrst), .bus_o(bus_o), .bus_oe(bus_oe),
        .ale_n(ale_n), .select(sel), .straps(straps), .pattern(pattern), .rd_byte(rd_byte),
        .bus_i(bus_i), .addr_seen(addr_seen), .addr_cnt(addr_cnt));

    always #20 clk_sys = ~clk_sys;

    task automatic check_pin(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want) begin
            bad_count++;
            $display("unexpected pin at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic cmp_read(input rps_exp_t e);
        if (e.mask != 32'h0) begin
            n_checks++;
            if ((avs_readdata & e.mask) !== (e.data & e.mask)) begin
                bad_count++;
                $display("unexpected read at %0t: got %h want %h", $time, avs_readdata, e.data);
            end
        end
    endtask
    // reads are judged in issue order; the latch clock must flip at every edge once running
    always @(posedge clk_sys) begin
        run_cnt <= nrst ? run_cnt + 1 : 0;
        lclk_d <= lclk;
        if (avs_read && wreq === 1'b0 && exp_q.size() > 0)
            cmp_read(exp_q.pop_front());
        if (nrst && run_cnt > 2 && lclk === lclk_d)
            check_pin(lclk, ~lclk_d);
    end
    // one avalon transfer; held until waitrequest is seen low, a zero mask only polls
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
                       input logic [31:0] m);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        if (!w)
            exp_q.push_back('{d, m});
        do begin
            @(posedge clk_sys);
            n++;
        end while (wreq !== 1'b0 && n < 300);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 300)
            check_pin(wreq, 32'h0);
    endtask
    // a preload always ends in ok or abort, so busy low before start is not taken as done
    task automatic wait_idle();
        // let a just-landed start request reach the sequencer before polling
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < 60; i++) begin
            bus(RPS_OFF_STATUS, 1'b0, 32'h0, 32'h0);
            if (rdata[RPS_ST_BUSY] === 1'b0 && (rdata[RPS_ST_PRE_OK] | rdata[RPS_ST_PRE_ABORT]))
                break;
        end
    endtask
    function automatic logic [31:0] status(input logic [4:0] s, input logic [1:0] p);
        return {20'h0, p != 2'h2, p == 2'h2, 1'b0, s[0], 3'h0, s};
    endfunction
    task automatic do_reset(input logic [1:0] p);
        straps <= 5'($random(seed));
        pattern <= p;
        nrst <= 1'b0;
        repeat (16) @(posedge clk_sys);
        check_pin({ale_n, sel, lclk, lock, bus_oe}, 32'h800);
        nrst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        wait_idle();
        check_pin({arb, sclk, asy, lock}, {straps[4], straps[2:0]});
        bus(RPS_OFF_STATUS, 1'b0, status(straps, p), 32'hf1f);
        sec_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check_pin({req_o, req_oe, zero_oe}, {1'b0, ~straps[3], ~straps[3]});
        sec_rst <= 1'b0;
        $display("reset test with pattern %b done", p);
    endtask

    initial begin
        #(40 * 20000);
        bad_count++;
        wrap_up();
    end
    initial begin
        do_reset(2'h2);
        do_reset(2'h0);
        do_reset(2'h3);
        do_reset(2'h2);
        for (int k = 0; k < 4; k++) begin
            pattern <= k[1:0];
            bus(RPS_OFF_CTRL, 1'b1, 32'h2, 32'h0);
            wait_idle();
            bus(RPS_OFF_STATUS, 1'b0, status(straps, pattern), 32'hc00);
        end
        $display("preload pattern test done");
        bus(RPS_OFF_CTRL, 1'b1, 32'h1, 32'h0);
        bus(RPS_OFF_STATUS, 1'b0, 32'h0, 32'h100);
        check_pin(lock, 32'h0);
        bus(5'h10, 1'b0, 32'h0, 32'hffffffff);
        $display("lockout and unmapped test done");
        for (int k = 0; k < 3; k++) begin
            addr[23:16] = 8'($random(seed));
            addr[15:0] = {addr[23:16] ^ 8'h55, addr[23:16] ^ 8'haa};
            rd_byte <= 8'($random(seed));
            bus(RPS_OFF_ADDR, 1'b1, {8'h00, addr}, 32'h0);
            bus(RPS_OFF_ADDR, 1'b0, {8'h00, addr}, 32'h00ffffff);
            bus(RPS_OFF_DATA, 1'b1, {24'h0, ~rd_byte}, 32'h0);
            check_pin({addr_cnt, addr_seen}, {2'h3, addr});
            bus(RPS_OFF_DATA, 1'b0, {24'h0, rd_byte}, 32'hff);
        end
        $display("parallel rom test done");
        wrap_up();
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
endmodule
